// File: rtl/mmo_memory_map.sv
/*
 address decoding and register access for the core's data spaces:
 internal ram, sfr space, external ram, pwm/display window, option access.
 assumes the cpu core holds a request for one cycle and takes rdata next cycle.
*/
// Summary of operation
// - option bit 4 low gives debug pins to debug; high frees them.
// - range code 00/01/10/11 allows self-programming of last 1K/2K/4K/all flash.
// - pointer at FEH selects an option register; FFH reads or writes it.
// - 256-byte ram; upper half indirect only, lower half direct or indirect.
// - direct accesses to 80H..FFH hit sfrs; indirect ones hit upper ram.
// - external ram 0000H..0FFFH only through external moves.
// - four register banks at 00H..1FH chosen by two status bits.
// - bytes 20H..2FH usable as bytes or as bits 00H..7FH.
// - indexed external address is page-high low nibble over the index.
// - page-high bits 3..0 read/write reset zero, bits 7..4 reserved.
// - window 1000H..104FH: display ram 1000H..101BH, pwm duty 1040H..104FH.
// - sfrs ending in 0 or 8 allow bit access; others byte only.
// - stack pointer resets to 07H.
// - option registers load from flash during reset initialisation.
`timescale 1ns/1ps
`default_nettype none
module mmo_memory_map #(
  parameter int IRAM_DEPTH = mmo_pkg::IRAM_BYTES,
  parameter int XRAM_DEPTH = mmo_pkg::XRAM_BYTES,
  parameter int WIN_DEPTH = 80
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // cpu access
  input wire mmo_pkg::mmo_req_s req,
  input wire logic [7:0] index_reg,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic unmapped,
  // option preload
  input wire logic opt_load_valid,
  input wire logic [7:0] opt_load_addr,
  input wire logic [7:0] opt_load_data,
  // option outputs
  output logic debug_port_disable,
  output logic debug_pins_dedicated,
  output logic [1:0] self_program_range,
  output logic [15:0] self_program_floor,
  output logic watchdog_enable_option,
  // core state
  output logic [1:0] active_bank,
  output logic [7:0] stack_pointer
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (IRAM_DEPTH != mmo_pkg::IRAM_BYTES) begin : g_bad_iram
    $error("unsupported internal ram depth");
  end
  if (XRAM_DEPTH != mmo_pkg::XRAM_BYTES) begin : g_bad_xram
    $error("unsupported external ram depth");
  end
  if (WIN_DEPTH != int'(mmo_pkg::WIN_LAST - mmo_pkg::WIN_BASE) + 1) begin : g_bad_win
    $error("unsupported window depth");
  end

  // 32k flash, top of the self-programming region
  localparam logic [15:0] FLASH_TOP = 16'h8000;

  logic [7:0] iram_q [IRAM_DEPTH];
  logic [7:0] xram_q [XRAM_DEPTH];
  logic [7:0] win_q [WIN_DEPTH];
  logic [7:0] stack_pointer_q;
  logic [7:0] status_q;
  logic [3:0] page_high_q;
  logic [7:0] option_pointer_q;
  logic [7:0] rdata_q;
  logic rvalid_q, unmapped_q;
  logic [7:0] opt_rd;
  logic opt_wr;
  mmo_pkg::mmo_opt_s opts;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_sfr(input mmo_pkg::mmo_req_s r);
    is_sfr = (r.kind == mmo_pkg::MMO_DIRECT) && r.addr[7];
  endfunction

  function automatic logic sfr_known(input logic [7:0] a);
    sfr_known = (a == mmo_pkg::SFR_STACK_POINTER) || (a == mmo_pkg::SFR_PROGRAM_STATUS) ||
                (a == mmo_pkg::SFR_EXT_PAGE_HIGH) || (a == mmo_pkg::SFR_OPTION_POINTER) ||
                (a == mmo_pkg::SFR_OPTION_VALUE);
  endfunction

  // bank registers mapped onto 00H..1FH; addresses r0..r7 go through status bits
  function automatic logic [7:0] iram_index(input mmo_pkg::mmo_req_s r, input logic [1:0] bank);
    if (r.kind == mmo_pkg::MMO_DIRECT && r.addr[7:3] == 5'h00 && r.addr[15]) begin
      iram_index = {3'h0, bank, r.addr[2:0]};
    end else begin
      iram_index = r.addr[7:0];
    end
  endfunction

  // external address: indexed form takes page-high nibble over the index
  function automatic logic [15:0] ext_addr(input mmo_pkg::mmo_req_s r, input logic [3:0] ph,
                                           input logic [7:0] idx);
    if (r.kind == mmo_pkg::MMO_EXT_INDEX) begin
      ext_addr = {4'h0, ph, idx};
    end else begin
      ext_addr = r.addr;
    end
  endfunction

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  logic [15:0] xa;
  logic [7:0] ia;
  logic [6:0] bit_byte;
  logic xram_hit, win_hit, win_gap, bit_sfr;
  logic [7:0] bit_sfr_addr;

  always_comb begin
    xa = ext_addr(req, page_high_q, index_reg);
    ia = iram_index(req, status_q[4:3]);
    xram_hit = (req.kind == mmo_pkg::MMO_EXT_INDEX || req.kind == mmo_pkg::MMO_EXT_WIDE) &&
               (xa < 16'(XRAM_DEPTH));
    // display/pwm gap holds nothing and reads as unmapped
    win_gap = (xa > mmo_pkg::LCD_LAST) && (xa < mmo_pkg::PWM_BASE);
    win_hit = (req.kind == mmo_pkg::MMO_EXT_INDEX || req.kind == mmo_pkg::MMO_EXT_WIDE) &&
              (xa >= mmo_pkg::WIN_BASE) && (xa <= mmo_pkg::WIN_LAST) && !win_gap;
    bit_byte = 7'(mmo_pkg::BIT_AREA_BASE) + {3'h0, req.addr[6:3]};
    bit_sfr = (req.kind == mmo_pkg::MMO_BIT) && req.addr[7];
    bit_sfr_addr = {req.addr[7:3], 3'h0};
  end

  // ---------------------------------------------------------------
  // internal ram
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (clk_en && req.valid && req.write) begin
      if ((req.kind == mmo_pkg::MMO_INDIRECT) ||
          (req.kind == mmo_pkg::MMO_DIRECT && !req.addr[7])) begin
        iram_q[ia] <= req.wdata;
      end else if (req.kind == mmo_pkg::MMO_BIT && !req.addr[7]) begin
        // one bit of 20h..2fh changes
        iram_q[{1'b0, bit_byte}][req.addr[2:0]] <= req.bit_value;
      end
    end
  end

  // ---------------------------------------------------------------
  // external ram and pwm/display window
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (clk_en && req.valid && req.write) begin
      if (xram_hit) begin
        xram_q[xa[11:0]] <= req.wdata;
      end else if (win_hit) begin
        win_q[7'(xa - mmo_pkg::WIN_BASE)] <= req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // sfrs held here
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_q <= mmo_pkg::RST_STACK_POINTER;
      status_q <= mmo_pkg::RST_PROGRAM_STATUS;
      page_high_q <= mmo_pkg::RST_EXT_PAGE_HIGH;
      option_pointer_q <= mmo_pkg::RST_OPTION_POINTER;
    end else if (clk_en && req.valid && req.write) begin
      if (is_sfr(req)) begin
        case (req.addr[7:0])
          mmo_pkg::SFR_STACK_POINTER: stack_pointer_q <= req.wdata;
          mmo_pkg::SFR_PROGRAM_STATUS: status_q <= req.wdata;
          mmo_pkg::SFR_EXT_PAGE_HIGH: page_high_q <= req.wdata[3:0];
          mmo_pkg::SFR_OPTION_POINTER: option_pointer_q <= req.wdata;
          default: ;
        endcase
      end else if (bit_sfr && bit_sfr_addr == mmo_pkg::SFR_PROGRAM_STATUS) begin
        // only the status word takes bit writes here
        status_q[req.addr[2:0]] <= req.bit_value;
      end
    end
  end

  // value-port writes land in the register the pointer selects
  assign opt_wr = clk_en && req.valid && req.write && is_sfr(req) &&
                  req.addr[7:0] == mmo_pkg::SFR_OPTION_VALUE;

  mmo_option_bank u_opt (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .load_valid(opt_load_valid),
    .load_addr(opt_load_addr),
    .load_data(opt_load_data),
    .pointer(option_pointer_q),
    .wr_en(opt_wr),
    .wr_data(req.wdata),
    .rd_data(opt_rd),
    .opts(opts)
  );

  // ---------------------------------------------------------------
  // read path, registered
  // ---------------------------------------------------------------
  // unassigned addresses read as zero
  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] sp,
                                          input logic [7:0] st, input logic [3:0] ph,
                                          input logic [7:0] op, input logic [7:0] ov);
    case (a)
      mmo_pkg::SFR_STACK_POINTER: sfr_read = sp;
      mmo_pkg::SFR_PROGRAM_STATUS: sfr_read = st;
      mmo_pkg::SFR_EXT_PAGE_HIGH: sfr_read = {4'h0, ph};
      mmo_pkg::SFR_OPTION_POINTER: sfr_read = op;
      mmo_pkg::SFR_OPTION_VALUE: sfr_read = ov;
      default: sfr_read = 8'h00;
    endcase
  endfunction

  // direct and bit reads each have their own sfr read mux
  logic [7:0] sfr_rd, bit_sfr_rd;
  assign sfr_rd = sfr_read(req.addr[7:0], stack_pointer_q, status_q, page_high_q,
                           option_pointer_q, opt_rd);
  assign bit_sfr_rd = sfr_read(bit_sfr_addr, stack_pointer_q, status_q, page_high_q,
                               option_pointer_q, opt_rd);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      unmapped_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q <= req.valid && !req.write;
      unmapped_q <= 1'b0;
      if (req.valid && !req.write) begin
        case (req.kind)
          mmo_pkg::MMO_DIRECT: begin
            if (req.addr[7]) begin
              rdata_q <= sfr_rd;
              unmapped_q <= !sfr_known(req.addr[7:0]);
            end else begin
              rdata_q <= iram_q[ia];
            end
          end
          mmo_pkg::MMO_INDIRECT: rdata_q <= iram_q[ia];
          mmo_pkg::MMO_BIT: begin
            if (bit_sfr) begin
              rdata_q <= {7'h00, bit_sfr_rd[req.addr[2:0]]};
              unmapped_q <= !sfr_known(bit_sfr_addr);
            end else begin
              rdata_q <= {7'h00, iram_q[{1'b0, bit_byte}][req.addr[2:0]]};
            end
          end
          mmo_pkg::MMO_EXT_INDEX, mmo_pkg::MMO_EXT_WIDE: begin
            if (xram_hit) begin
              rdata_q <= xram_q[xa[11:0]];
            end else if (win_hit) begin
              rdata_q <= win_q[7'(xa - mmo_pkg::WIN_BASE)];
            end else begin
              rdata_q <= 8'h00;
              unmapped_q <= 1'b1;
            end
          end
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // lowest flash address open to self-programming
  always_comb begin
    case (opts.self_program_range)
      2'b00: self_program_floor = FLASH_TOP - 16'h0400;
      2'b01: self_program_floor = FLASH_TOP - 16'h0800;
      2'b10: self_program_floor = FLASH_TOP - 16'h1000;
      default: self_program_floor = 16'h0000;
    endcase
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign unmapped = unmapped_q;
  assign debug_port_disable = opts.debug_port_disable;
  assign debug_pins_dedicated = !opts.debug_port_disable;
  assign self_program_range = opts.self_program_range;
  assign watchdog_enable_option = opts.watchdog_enable_option;
  assign active_bank = status_q[4:3];
  assign stack_pointer = stack_pointer_q;
endmodule // mmo_memory_map
`default_nettype wire

// File: rtl/mmo_pkg.sv
/*
 memory-map and option-access constants, types and bus carriers.
 assumes a single clock domain; used by the decoder and the option bank.
*/
`default_nettype none
package mmo_pkg;
  // ---------------------------------------------------------------
  // sfr offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_STACK_POINTER = 8'h81;
  localparam logic [7:0] SFR_PROGRAM_STATUS = 8'hd0;
  localparam logic [7:0] SFR_EXT_PAGE_HIGH = 8'hf7;
  localparam logic [7:0] SFR_OPTION_POINTER = 8'hfe;
  localparam logic [7:0] SFR_OPTION_VALUE = 8'hff;
  // ---------------------------------------------------------------
  // option register addresses and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OPT_ADDR_CLOCK_TRIM = 8'h83;
  localparam logic [7:0] OPT_ADDR_ZERO = 8'hc1;
  localparam logic [7:0] OPT_ADDR_ONE = 8'hc2;
  localparam int OPT_DEBUG_DISABLE_BIT = 4;
  localparam int OPT_RANGE_LSB = 2;
  localparam int OPT_WATCHDOG_BIT = 7;
  localparam logic [7:0] OPT_ONE_WRITABLE = 8'hdc;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_PROGRAM_STATUS = 8'h00;
  localparam logic [3:0] RST_EXT_PAGE_HIGH = 4'h0;
  localparam logic [7:0] RST_OPTION_POINTER = 8'h00;
  // ---------------------------------------------------------------
  // memory map
  // ---------------------------------------------------------------
  localparam int IRAM_BYTES = 256;
  localparam int XRAM_BYTES = 4096;
  localparam logic [15:0] WIN_BASE = 16'h1000;
  localparam logic [15:0] WIN_LAST = 16'h104f;
  localparam logic [15:0] LCD_LAST = 16'h101b;
  localparam logic [15:0] PWM_BASE = 16'h1040;
  localparam logic [7:0] BANK_LAST = 8'h1f;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  // ---------------------------------------------------------------
  // access kinds and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MMO_DIRECT, MMO_INDIRECT, MMO_BIT, MMO_EXT_INDEX, MMO_EXT_WIDE
  } mmo_kind_e;
  typedef struct packed {
    logic valid;
    logic write;
    mmo_kind_e kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic bit_value;
  } mmo_req_s;
  typedef struct packed {
    logic debug_port_disable;
    logic [1:0] self_program_range;
    logic watchdog_enable_option;
  } mmo_opt_s;
endpackage
`default_nettype wire

// File: rtl/mmo_option_bank.sv
/*
 option register bank reached through the pointer/value pair.
 assumes option images arrive on load_valid during reset initialisation.
*/
`timescale 1ns/1ps
`default_nettype none
module mmo_option_bank (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // preload from flash
  input wire logic load_valid,
  input wire logic [7:0] load_addr,
  input wire logic [7:0] load_data,
  // cpu access via value port
  input wire logic [7:0] pointer,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // decoded options
  output mmo_pkg::mmo_opt_s opts
);
  logic [7:0] trim_q, zero_q, one_q;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= 8'h00;
      zero_q <= 8'h00;
      one_q <= 8'h00;
    end else if (clk_en) begin
      if (load_valid) begin
        case (load_addr)
          mmo_pkg::OPT_ADDR_CLOCK_TRIM: trim_q <= load_data;
          mmo_pkg::OPT_ADDR_ZERO: zero_q <= load_data;
          mmo_pkg::OPT_ADDR_ONE: one_q <= load_data & mmo_pkg::OPT_ONE_WRITABLE;
          default: ;
        endcase
      end else if (wr_en) begin
        case (pointer)
          mmo_pkg::OPT_ADDR_CLOCK_TRIM: trim_q <= wr_data;
          mmo_pkg::OPT_ADDR_ZERO: zero_q <= wr_data;
          mmo_pkg::OPT_ADDR_ONE: one_q <= wr_data & mmo_pkg::OPT_ONE_WRITABLE;
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux, no side effects
  // ---------------------------------------------------------------
  always_comb begin
    case (pointer)
      mmo_pkg::OPT_ADDR_CLOCK_TRIM: rd_data = trim_q;
      mmo_pkg::OPT_ADDR_ZERO: rd_data = zero_q;
      mmo_pkg::OPT_ADDR_ONE: rd_data = one_q;
      default: rd_data = 8'h00;
    endcase
  end

  assign opts.debug_port_disable = one_q[mmo_pkg::OPT_DEBUG_DISABLE_BIT];
  assign opts.self_program_range = one_q[mmo_pkg::OPT_RANGE_LSB +: 2];
  assign opts.watchdog_enable_option = zero_q[mmo_pkg::OPT_WATCHDOG_BIT];
endmodule // mmo_option_bank
`default_nettype wire

// File: test/mmo_memory_map_asserts.sv
/*
 port checker for the memory map block.
 assumes one clock domain and an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mmo_memory_map_asserts #(parameter int IRAM_DEPTH = 256, parameter int XRAM_DEPTH = 4096,
  parameter int WIN_DEPTH = 80) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cpu side
  input wire logic clk_en,
  input wire mmo_pkg::mmo_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic unmapped,
  // option and core outputs
  input wire logic debug_port_disable,
  input wire logic debug_pins_dedicated,
  input wire logic [1:0] self_program_range,
  input wire logic [15:0] self_program_floor,
  input wire logic [1:0] active_bank,
  input wire logic [7:0] stack_pointer
);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rd(k, a);
    clk_en && req.valid && !req.write && req.kind == k && req.addr == a;
  endsequence
  sequence s_wr(k, a);
    clk_en && req.valid && req.write && req.kind == k && req.addr == a;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_read_answer;
    clk_en && req.valid && !req.write |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_unmapped_zero;
    unmapped |-> rvalid && rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("refused read not zero");
  property p_debug_pins;
    debug_pins_dedicated == !debug_port_disable;
  endproperty
  a_debug_pins: assert property (p_debug_pins) else $error("debug pin use wrong");
  property p_floor;
    self_program_floor == (self_program_range == 2'b00 ? 16'h7c00 : self_program_range == 2'b01 ? 16'h7800 :
      self_program_range == 2'b10 ? 16'h7000 : 16'h0000);
  endproperty
  a_floor: assert property (p_floor) else $error("program floor wrong");
  property p_sp_reset;
    $rose(rst_n) |-> stack_pointer == 8'h07;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset wrong");
  property p_sp_direct;
    s_rd(mmo_pkg::MMO_DIRECT, 16'h0081) |=> rdata == $past(stack_pointer);
  endproperty
  a_sp_direct: assert property (p_sp_direct) else $error("direct read missed sfr");
  property p_page_high;
    s_wr(mmo_pkg::MMO_DIRECT, 16'h00f7) ##1 s_rd(mmo_pkg::MMO_DIRECT, 16'h00f7)
      |=> rdata[3:0] == $past(req.wdata[3:0], 2);
  endproperty
  a_page_high: assert property (p_page_high) else $error("page high readback wrong");
  property p_bank;
    s_wr(mmo_pkg::MMO_DIRECT, 16'h00d0) |=> active_bank == $past(req.wdata[4:3]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_ext_refused;
    clk_en && req.valid && !req.write && req.kind == mmo_pkg::MMO_EXT_WIDE &&
      req.addr inside {[16'h101c:16'h103f], [16'h1050:16'hffff]} |=> unmapped;
  endproperty
  a_ext_refused: assert property (p_ext_refused) else $error("gap read not refused");
endmodule // mmo_memory_map_asserts
`default_nettype wire

// File: test/mmo_cpu_model.sv
/*
 cpu core model issuing one access per edge on the request carrier.
 assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mmo_cpu_model (
  // clock
  input wire logic clock,
  // answers
  input wire logic [7:0] rdata,
  // requests
  output mmo_pkg::mmo_req_s req,
  output logic [7:0] index_reg,
  output logic clk_en
);
  initial begin
    req = '0;
    index_reg = 8'h00;
    clk_en = 1'b1;
  end
  // held until the edge that takes it
  task automatic acc(input logic w, input mmo_pkg::mmo_kind_e k, input logic [15:0] a, input logic [7:0] v,
    input logic b);
    req <= '{valid: 1'b1, write: w, kind: k, addr: a, wdata: v, bit_value: b};
    @(posedge clock);
  endtask
  // release, then a slow core stalls with the enable low
  task automatic idle(input int stall);
    req.valid <= 1'b0;
    @(posedge clock);
    if (stall > 0) begin
      clk_en <= 1'b0;
      repeat (stall) @(posedge clock);
      clk_en <= 1'b1;
    end
  endtask
  task automatic set_index(input logic [7:0] v);
    index_reg <= v;
  endtask
  // pointer first, then or into the value port
  task automatic rmw_or(input logic [7:0] ptr, input logic [7:0] mask);
    logic [7:0] cur;
    if (!(ptr inside {8'h83, 8'hc1, 8'hc2})) begin
      ptr = 8'hc1;
    end
    acc(1'b1, mmo_pkg::MMO_DIRECT, 16'h00fe, ptr, 1'b0);
    acc(1'b0, mmo_pkg::MMO_DIRECT, 16'h00ff, 8'h00, 1'b0);
    idle(0);
    cur = rdata;
    acc(1'b1, mmo_pkg::MMO_DIRECT, 16'h00ff, cur | mask, 1'b0);
  endtask
endmodule // mmo_cpu_model
`default_nettype wire

// File: test/mmo_memory_map_tb.sv
/*
 self-checking bench for the memory map block driven by a cpu model.
 assumes the port checker is bound to the design top below.
*/
`timescale 1ns/1ps
`default_nettype none
module mmo_memory_map_tb;
  logic clock, rst_n, clk_en, rvalid, unmapped, opt_load_valid, dis, dedicated, wdog;
  mmo_pkg::mmo_req_s req;
  logic [7:0] index_reg, rdata, opt_load_addr, opt_load_data, sp, d;
  logic [1:0] rng, bank;
  logic [15:0] flr;
  logic [8:0] expq[$];
  logic [15:0] floors [4] = '{16'h7c00, 16'h7800, 16'h7000, 16'h0000};
  logic [15:0] wins [7] = '{16'h1000, 16'h101b, 16'h101c, 16'h1040, 16'h104f, 16'h1050, 16'h0fff};
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  mmo_memory_map mmo_memory_map_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .index_reg(index_reg), .rdata(rdata), .rvalid(rvalid), .unmapped(unmapped), .opt_load_valid(opt_load_valid),
    .opt_load_addr(opt_load_addr), .opt_load_data(opt_load_data), .debug_port_disable(dis),
    .debug_pins_dedicated(dedicated), .self_program_range(rng), .self_program_floor(flr),
    .watchdog_enable_option(wdog), .active_bank(bank), .stack_pointer(sp));
  mmo_cpu_model mmo_cpu_model_inst (.clock(clock), .rdata(rdata), .req(req), .index_reg(index_reg),
    .clk_en(clk_en));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (rst_n && clk_en && rvalid) begin
      if (expq.size() == 0) begin
        check("spare answer", 16'h1, 16'h0);
      end else begin
        check("read answer", {unmapped, rdata}, expq.pop_front());
      end
    end
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic rd(input mmo_pkg::mmo_kind_e k, input logic [15:0] a, input logic [8:0] e);
    expq.push_back(e);
    mmo_cpu_model_inst.acc(1'b0, k, a, 8'h00, 1'b0);
  endtask
  task automatic wr(input mmo_pkg::mmo_kind_e k, input logic [15:0] a, input logic [7:0] v);
    mmo_cpu_model_inst.acc(1'b1, k, a, v, 1'b0);
  endtask
  task automatic opts(input logic ds, input logic [1:0] r, input logic w);
    mmo_cpu_model_inst.idle(0);
    #1;
    check("debug_port_disable", dis, ds);
    check("debug_pins_dedicated", dedicated, !ds);
    check("self_program_floor", flr, floors[r]);
    check("self_program_range", rng, r);
    check("watchdog_enable_option", wdog, w);
    @(posedge clock);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    opt_load_valid = 1'b0;
    opt_load_addr = 8'h00;
    opt_load_data = 8'h00;
    d = 8'($urandom(32'hda6e));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check("stack_pointer", sp, 8'h07);
    check("active_bank", bank, 2'b00);
    @(posedge clock);
    opt_load_valid <= 1'b1;
    opt_load_addr <= 8'hc1;
    opt_load_data <= {1'b0, d[6:0]};
    @(posedge clock);
    opt_load_addr <= 8'hc2;
    opt_load_data <= 8'hff;
    @(posedge clock);
    opt_load_valid <= 1'b0;
    opts(1'b1, 2'b11, 1'b0);
    wr(mmo_pkg::MMO_DIRECT, 16'h00fe, 8'hc2);
    rd(mmo_pkg::MMO_DIRECT, 16'h00ff, {1'b0, mmo_pkg::OPT_ONE_WRITABLE});
    expq.push_back({2'b00, d[6:0]});
    mmo_cpu_model_inst.rmw_or(8'hc1, 8'h80);
    rd(mmo_pkg::MMO_DIRECT, 16'h00ff, {2'b01, d[6:0]});
    for (int i = 0; i < 4; i++) begin
      wr(mmo_pkg::MMO_DIRECT, 16'h00fe, 8'hc2);
      wr(mmo_pkg::MMO_DIRECT, 16'h00ff, {3'b000, i[0], i[1:0], 2'b00});
      opts(i[0], i[1:0], 1'b1);
    end
    wr(mmo_pkg::MMO_DIRECT, 16'h00fe, mmo_pkg::OPT_ADDR_CLOCK_TRIM);
    wr(mmo_pkg::MMO_DIRECT, 16'h00ff, ~d);
    rd(mmo_pkg::MMO_DIRECT, 16'h00ff, {1'b0, ~d});
    wr(mmo_pkg::MMO_INDIRECT, 16'h0081, d);
    rd(mmo_pkg::MMO_DIRECT, 16'h0081, 9'h007);
    rd(mmo_pkg::MMO_INDIRECT, 16'h0081, {1'b0, d});
    wr(mmo_pkg::MMO_DIRECT, 16'h0081, ~d);
    rd(mmo_pkg::MMO_DIRECT, 16'h0081, {1'b0, ~d});
    wr(mmo_pkg::MMO_DIRECT, 16'h0042, d);
    rd(mmo_pkg::MMO_INDIRECT, 16'h0042, {1'b0, d});
    rd(mmo_pkg::MMO_DIRECT, 16'h00e1, 9'h100);
    mmo_cpu_model_inst.idle($urandom_range(3, 1));
    wr(mmo_pkg::MMO_DIRECT, 16'h00d0, 8'h18);
    wr(mmo_pkg::MMO_DIRECT, 16'h8003, d);
    rd(mmo_pkg::MMO_INDIRECT, 16'h001b, {1'b0, d});
    mmo_cpu_model_inst.acc(1'b1, mmo_pkg::MMO_BIT, 16'h00d3, 8'h00, 1'b0);
    rd(mmo_pkg::MMO_BIT, 16'h00d4, 9'h001);
    rd(mmo_pkg::MMO_DIRECT, 16'h00d0, 9'h010);
    wr(mmo_pkg::MMO_INDIRECT, 16'h0021, 8'h04);
    rd(mmo_pkg::MMO_BIT, 16'h000a, 9'h001);
    rd(mmo_pkg::MMO_BIT, 16'h000b, 9'h000);
    mmo_cpu_model_inst.acc(1'b1, mmo_pkg::MMO_BIT, 16'h000f, 8'h00, 1'b1);
    rd(mmo_pkg::MMO_DIRECT, 16'h0021, 9'h084);
    wr(mmo_pkg::MMO_DIRECT, 16'h00f7, 8'hf5);
    rd(mmo_pkg::MMO_DIRECT, 16'h00f7, 9'h005);
    mmo_cpu_model_inst.set_index(8'h34);
    wr(mmo_pkg::MMO_EXT_INDEX, 16'h0000, d);
    rd(mmo_pkg::MMO_EXT_WIDE, 16'h0534, {1'b0, d});
    rd(mmo_pkg::MMO_EXT_WIDE, 16'h2000, 9'h100);
    foreach (wins[i]) begin
      wr(mmo_pkg::MMO_EXT_WIDE, wins[i], d ^ 8'(i));
      rd(mmo_pkg::MMO_EXT_WIDE, wins[i], (wins[i] inside {[16'h101c:16'h103f], [16'h1050:16'hffff]}) ?
        9'h100 : {1'b0, d ^ 8'(i)});
      mmo_cpu_model_inst.idle($urandom_range(2, 0));
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check("stack_pointer", sp, 8'h07);
    @(posedge clock);
    rd(mmo_pkg::MMO_DIRECT, 16'h00f7, 9'h000);
    opts(1'b0, 2'b00, 1'b0);
    check("pending answers", 16'(expq.size()), 16'h0000);
    conclude();
  end
endmodule // mmo_memory_map_tb
bind mmo_memory_map mmo_memory_map_asserts #(.IRAM_DEPTH(IRAM_DEPTH), .XRAM_DEPTH(XRAM_DEPTH),
  .WIN_DEPTH(WIN_DEPTH)) mmo_memory_map_asserts_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
  .req(req), .rdata(rdata), .rvalid(rvalid), .unmapped(unmapped), .debug_port_disable(debug_port_disable),
  .debug_pins_dedicated(debug_pins_dedicated), .self_program_range(self_program_range),
  .self_program_floor(self_program_floor), .active_bank(active_bank), .stack_pointer(stack_pointer));
`default_nettype wire
